// *** inc/balrb_pkg.sv ***
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package balrb_pkg;
  // register word index; byte address is four times the index
  localparam logic [7:0]  REG_READBACK_IDX = 8'h83;
  localparam logic [11:0] ADDR_READBACK    = {2'h0, REG_READBACK_IDX, 2'h0};
  localparam logic [11:0] ADDR_MODE        = 12'h400;
  localparam logic [11:0] ADDR_IRQ_STATUS  = 12'h404;
  localparam logic [11:0] ADDR_IRQ_MASK    = 12'h408;
  localparam int          STATE_LSB        = 14;
  localparam int          READY_BIT        = 13;
  localparam int          STROBE_BIT       = 0;
  localparam int          CBMODE_W         = 3;
  localparam int          MEASEN_W         = 2;
  localparam int          IRQ_W            = 3;
  localparam int          IRQ_READY        = 0;
  localparam int          IRQ_DONE         = 1;
  localparam int          IRQ_FAULT        = 2;
  localparam logic [1:0]  STATE_RESET      = 2'h0;
  localparam logic [CBMODE_W-1:0] CBMODE_DISABLED = 3'h0;
  localparam logic [CBMODE_W-1:0] CBMODE_MANUAL   = 3'h1;
  localparam int          COPY_CYCLES      = 2;
  typedef enum logic [1:0] {
    BAL_DISABLED = 2'h0,
    BAL_ACTIVE   = 2'h1,
    BAL_DONE     = 2'h2,
    BAL_HALTED   = 2'h3
  } bal_state_t;
endpackage

// *** inc/copy_if.sv ***
`timescale 1ns/1ps
// request/done pair between register file and copy sequencer
interface copy_if;
  logic req;
  logic done;
  logic busy;
  modport ctrl (output req, input done, input busy);
  modport seq  (input req, output done, output busy);
endinterface

// *** core/copy_sequencer.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// transfer sequencer: issue a one-cycle latch pulse, count CYCLES, then report done
// ----------------------------------------------------------------------------
module copy_sequencer
  import balrb_pkg::*;
#(
  parameter int CYCLES = COPY_CYCLES
)
(
  input  wire logic clk,
  input  wire logic rstn,
  copy_if.seq       cp,
  output logic      latchPulse
);
  logic [3:0] cnt_reg;
  // the counter is four bits wide, so longer copies cannot be served
  if (CYCLES < 1 || CYCLES > 15)
  begin : g_bad_cycles
    $error("CYCLES out of range");
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_reg    <= 4'h0;
      latchPulse <= 1'b0;
      cp.done    <= 1'b0;
      cp.busy    <= 1'b0;
    end
    else
    begin
      latchPulse <= 1'b0;
      cp.done    <= 1'b0;
      if (!cp.busy && cp.req)
      begin
        cp.busy    <= 1'b1;
        latchPulse <= 1'b1;
        cnt_reg    <= 4'(CYCLES);
      end
      else if (cp.busy)
      begin
        if (cnt_reg == 4'h1)
        begin
          cp.busy <= 1'b0;
          cp.done <= 1'b1;
        end
        cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end
endmodule // copy_sequencer

// *** core/balancing_readback_control.sv ***
`timescale 1ns/1ps
module balancing_readback_control
  import balrb_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  input  wire logic                 hsel,
  input  wire logic [11:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire logic                 balActive,
  input  wire logic                 balDoneNormal,
  input  wire logic                 balFault,
  input  wire logic                 acqResultsLoaded,
  input  wire logic [balrb_pkg::MEASEN_W-1:0] measEnable,
  output logic                      filterLatch,
  output logic                      measurementReadyFlag,
  output logic                      irq
);
  import balrb_pkg::*;

  // --------------------------------------------------------------------------
  // reset release
  // --------------------------------------------------------------------------
  logic rstSync1, rstn;
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rstSync1 <= 1'b0;
      rstn     <= 1'b0;
    end
    else
    begin
      rstSync1 <= 1'b1;
      rstn     <= rstSync1;
    end
  end

  // --------------------------------------------------------------------------
  // ahb-lite address phase capture
  // --------------------------------------------------------------------------
  logic        wrPend_reg, rdPend_reg;
  logic [11:0] addr_reg;
  logic        take;
  assign take = hsel && hready && htrans[1];

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wrPend_reg <= 1'b0;
      rdPend_reg <= 1'b0;
      addr_reg   <= 12'h000;
    end
    else if (hready)
    begin
      wrPend_reg <= take && hwrite;
      rdPend_reg <= take && !hwrite;
      addr_reg   <= haddr;
    end
  end

  logic wrReadback, wrMode, wrStatus, wrMask;
  assign wrReadback = wrPend_reg && addr_reg == ADDR_READBACK;
  assign wrMode     = wrPend_reg && addr_reg == ADDR_MODE;
  assign wrStatus   = wrPend_reg && addr_reg == ADDR_IRQ_STATUS;
  assign wrMask     = wrPend_reg && addr_reg == ADDR_IRQ_MASK;

  // --------------------------------------------------------------------------
  // balancing mode and state field
  // --------------------------------------------------------------------------
  logic [CBMODE_W-1:0] cbMode_reg;
  bal_state_t          balState_reg;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      cbMode_reg <= CBMODE_DISABLED;
    else if (wrMode)
      cbMode_reg <= hwdata[CBMODE_W-1:0];
  end

  // a fault outranks a normal finish reported in the same cycle
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      balState_reg <= bal_state_t'(STATE_RESET);
    else if (balFault)
      balState_reg <= BAL_HALTED;
    else if (balDoneNormal)
      balState_reg <= BAL_DONE;
    else if (balActive)
      balState_reg <= BAL_ACTIVE;
    else if (cbMode_reg == CBMODE_DISABLED)
      balState_reg <= BAL_DISABLED;
  end

  // --------------------------------------------------------------------------
  // transfer strobe
  // --------------------------------------------------------------------------
  copy_if cp ();
  logic   strobeOk, copyReq_reg, latchPulse;
  // modes manual/disabled and measure enable 0x block the strobe
  assign strobeOk = cbMode_reg != CBMODE_DISABLED && cbMode_reg != CBMODE_MANUAL
                    && measEnable[MEASEN_W-1];

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      copyReq_reg <= 1'b0;
    else
      copyReq_reg <= wrReadback && hwdata[STROBE_BIT] && strobeOk;
  end
  assign cp.req = copyReq_reg;

  copy_sequencer #(.CYCLES(COPY_CYCLES)) u_seq (
    .clk        (sys_clk),
    .rstn       (rstn),
    .cp         (cp.seq),
    .latchPulse (latchPulse)
  );

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      filterLatch <= 1'b0;
    else
      filterLatch <= latchPulse;
  end

  // --------------------------------------------------------------------------
  // ready flag: single flop, mirror read from it
  // --------------------------------------------------------------------------
  // the measurement ready flag and its mirror at bit 13 are one flop, so
  // the two copies can never disagree, even for a single cycle
  // any write to the readback word with bit 13 low clears it unless a set arrives in the same cycle,
  // the strobe write included; a copy finishing later sets it again
  logic readySet, readyClr;
  assign readySet = acqResultsLoaded || cp.done;
  assign readyClr = wrReadback && !hwdata[READY_BIT];

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      measurementReadyFlag <= 1'b0;
    else if (readySet)
      measurementReadyFlag <= 1'b1;
    else if (readyClr)
      measurementReadyFlag <= 1'b0;
  end

  // --------------------------------------------------------------------------
  // interrupts
  // --------------------------------------------------------------------------
  // status bits are sticky and cleared by writing one; an event in the
  // same cycle as its clear wins, so no event is ever lost
  logic [IRQ_W-1:0] irqStatus_reg, irqMask_reg, irqEvent;
  assign irqEvent = {balFault, balDoneNormal, readySet};

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      irqMask_reg <= '0;
    else if (wrMask)
      irqMask_reg <= hwdata[IRQ_W-1:0];
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      irqStatus_reg <= '0;
    else
      irqStatus_reg <= irqEvent | (irqStatus_reg & ~({IRQ_W{wrStatus}} & hwdata[IRQ_W-1:0]));
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      irq <= 1'b0;
    else
      irq <= |(irqEvent | (irqStatus_reg & irqMask_reg)) && |(irqMask_reg &
             (irqEvent | irqStatus_reg));
  end

  // --------------------------------------------------------------------------
  // read data, zero wait states
  // --------------------------------------------------------------------------
  logic [31:0] rdNext;
  always_comb
  begin
    rdNext = 32'h0000_0000;
    unique case (haddr)
      ADDR_READBACK:
      begin
        rdNext[STATE_LSB+1:STATE_LSB] = balState_reg;
        rdNext[READY_BIT]             = measurementReadyFlag;
        // bits 12:1 and strobe stay zero
      end
      ADDR_MODE:       rdNext[CBMODE_W-1:0] = cbMode_reg;
      ADDR_IRQ_STATUS: rdNext[IRQ_W-1:0]    = irqStatus_reg;
      ADDR_IRQ_MASK:   rdNext[IRQ_W-1:0]    = irqMask_reg;
      default:         rdNext = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else if (take && !hwrite)
      hrdata <= rdNext;
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  a_strobe_blocked: assert property (@(posedge sys_clk) disable iff (!rstn)
    (wrReadback && !strobeOk) |=> !copyReq_reg)
    else $error("strobe acted while blocked");
  a_copy_sets_ready: assert property (@(posedge sys_clk) disable iff (!rstn)
    copyReq_reg |-> ##[1:4] measurementReadyFlag)
    else $error("copy did not set ready");
  a_ready_set_wins: assert property (@(posedge sys_clk) disable iff (!rstn)
    readySet |=> measurementReadyFlag)
    else $error("ready not set");
  a_ready_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
    (readyClr && !readySet) |=> !measurementReadyFlag)
    else $error("ready not cleared");
  a_ready_one_ignored: assert property (@(posedge sys_clk) disable iff (!rstn)
    (wrReadback && hwdata[READY_BIT] && !measurementReadyFlag && !readySet)
    |=> !measurementReadyFlag)
    else $error("write one set ready");
  a_fault_state: assert property (@(posedge sys_clk) disable iff (!rstn)
    balFault |=> balState_reg == BAL_HALTED)
    else $error("fault state wrong");
  a_done_state: assert property (@(posedge sys_clk) disable iff (!rstn)
    (balDoneNormal && !balFault) |=> balState_reg == BAL_DONE)
    else $error("done state wrong");
  a_active_state: assert property (@(posedge sys_clk) disable iff (!rstn)
    (balActive && !balFault && !balDoneNormal) |=> balState_reg == BAL_ACTIVE)
    else $error("active state wrong");
  a_unused_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
    (take && !hwrite && haddr == ADDR_READBACK) |=> hrdata[12:0] == 13'h0000)
    else $error("unused bits nonzero");
  a_mirror_read: assert property (@(posedge sys_clk) disable iff (!rstn)
    (take && !hwrite && haddr == ADDR_READBACK)
    |=> hrdata[READY_BIT] == $past(measurementReadyFlag))
    else $error("mirror mismatch");

  // --------------------------------------------------------------------------
  // copy path, state field, interrupt and bus path checks
  // --------------------------------------------------------------------------
  // a latch pulse only follows an accepted strobe request
  a_latch_from_req: assert property (@(posedge sys_clk) disable iff (!rstn)
    latchPulse
    |-> $past(copyReq_reg))
    else $error("latch without request");

  // one strobe write gives one latch pulse, never a held level
  a_latch_single: assert property (@(posedge sys_clk) disable iff (!rstn)
    filterLatch
    |=> !filterLatch)
    else $error("latch pulse too long");

  // a started copy always reports done within the counter's reach
  a_copy_bounded: assert property (@(posedge sys_clk) disable iff (!rstn)
    $rose(cp.busy)
    |-> ##[1:16] cp.done)
    else $error("copy never finished");

  a_state_disabled: assert property (@(posedge sys_clk) disable iff (!rstn)
    (cbMode_reg == CBMODE_DISABLED && !balActive && !balFault && !balDoneNormal)
    |=> balState_reg == BAL_DISABLED)
    else $error("state not disabled");

  // while the mode is not disabled, a finished or halted code stays visible until something new happens
  a_state_holds: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!balFault && !balDoneNormal && !balActive && cbMode_reg != CBMODE_DISABLED)
    |=> $stable(balState_reg))
    else $error("state changed by itself");

  a_ready_holds: assert property (@(posedge sys_clk) disable iff (!rstn)
    (!readySet && !readyClr)
    |=> $stable(measurementReadyFlag))
    else $error("ready flag changed by itself");

  a_status_sticky: assert property (@(posedge sys_clk) disable iff (!rstn)
    (irqStatus_reg[IRQ_READY] && !(wrStatus && hwdata[IRQ_READY]))
    |=> irqStatus_reg[IRQ_READY])
    else $error("status bit lost");

  // the output lags the masked status and new events by exactly one flop
  a_irq_level: assert property (@(posedge sys_clk) disable iff (!rstn)
    1'b1
    |=> irq == $past(|(irqMask_reg & (irqEvent | irqStatus_reg))))
    else $error("irq level wrong");

  a_bus_okay: assert property (@(posedge sys_clk) disable iff (!rstn)
    1'b1
    |-> hreadyout && !hresp)
    else $error("wait state or error response");

  a_hrdata_held: assert property (@(posedge sys_clk) disable iff (!rstn)
    !(take && !hwrite)
    |=> $stable(hrdata))
    else $error("read data moved without read");

  a_strobe_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
    (take && !hwrite && haddr == ADDR_READBACK)
    |=> !hrdata[STROBE_BIT])
    else $error("strobe read back as one");

  a_upper_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
    (take && !hwrite && haddr == ADDR_READBACK)
    |=> hrdata[31:16] == 16'h0000)
    else $error("upper half nonzero");

  a_state_read: assert property (@(posedge sys_clk) disable iff (!rstn)
    (take && !hwrite && haddr == ADDR_READBACK)
    |=> hrdata[STATE_LSB+1:STATE_LSB] == $past(balState_reg))
    else $error("state field read wrong");

  a_ready_on_load: assert property (@(posedge sys_clk) disable iff (!rstn)
    acqResultsLoaded
    |=> measurementReadyFlag)
    else $error("load did not set ready");

  c_refused: cover property (@(posedge sys_clk) disable iff (!rstn)
    wrReadback && hwdata[STROBE_BIT] && !strobeOk);
  c_copy: cover property (@(posedge sys_clk) disable iff (!rstn) cp.done);
  c_fault: cover property (@(posedge sys_clk) disable iff (!rstn) balFault);
  c_irq: cover property (@(posedge sys_clk) disable iff (!rstn) irq);
endmodule // balancing_readback_control

// *** bench/test_balancing_readback_control.sv ***
`timescale 1ns/1ps
module test_balancing_readback_control;
  import balrb_pkg::*;
  logic        sys_clk;
  logic        resetn;
  logic        hsel;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        balActive;
  logic        balDoneNormal;
  logic        balFault;
  logic        acqResultsLoaded;
  logic [1:0]  measEnable;
  logic        filterLatch;
  logic        measurementReadyFlag;
  logic        irq;
  int          err_total = 0;
  int          n_tests = 0;
  int          latchCnt = 0;

  balancing_readback_control u_balancing_readback_control (
    .sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .balActive(balActive),
    .balDoneNormal(balDoneNormal), .balFault(balFault), .acqResultsLoaded(acqResultsLoaded),
    .measEnable(measEnable), .filterLatch(filterLatch),
    .measurementReadyFlag(measurementReadyFlag), .irq(irq));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
    if (filterLatch === 1'b1)
      latchCnt <= latchCnt + 1;

  task automatic wrap_up();
    $display("mismatches %0d of %0d checks", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t %s got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // one whole-word single transfer; every change lands just after an edge
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    hsize  <= 3'h2;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    r = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(a, 1'b1, d, r);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string m);
    logic [31:0] r;
    bus(a, 1'b0, 32'h0, r);
    chk(r, exp, m);
    chk({hreadyout, hresp}, 2'h2, "okay response");
  endtask

  function automatic logic [31:0] bal(input logic [1:0] s, input logic f);
    return {16'h0, s, f, 13'h0};
  endfunction

  task automatic acqPulse();
    acqResultsLoaded <= 1'b1;
    cyc(1);
    acqResultsLoaded <= 1'b0;
    cyc(2);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic testState();
    wr(ADDR_MODE, 32'h2);
    balActive <= 1'b1;
    cyc(2);
    balActive <= 1'b0;
    rd(ADDR_READBACK, bal(2'h1, 1'b0), "state active");
    balDoneNormal <= 1'b1;
    cyc(1);
    balDoneNormal <= 1'b0;
    cyc(2);
    rd(ADDR_READBACK, bal(2'h2, 1'b0), "state done");
    balDoneNormal <= 1'b1;
    balFault <= 1'b1;
    cyc(1);
    balDoneNormal <= 1'b0;
    balFault <= 1'b0;
    cyc(2);
    rd(ADDR_READBACK, bal(2'h3, 1'b0), "state fault wins");
    wr(ADDR_MODE, 32'h0);
    cyc(2);
    rd(ADDR_READBACK, bal(2'h0, 1'b0), "state disabled");
  endtask

  task automatic testReady();
    acqPulse();
    chk(measurementReadyFlag, 1'b1, "flag after load");
    rd(ADDR_READBACK, bal(2'h0, 1'b1), "mirror set");
    wr(ADDR_READBACK, 32'h2000);
    rd(ADDR_READBACK, bal(2'h0, 1'b1), "write one ignored");
    wr(ADDR_READBACK, 32'h0);
    rd(ADDR_READBACK, bal(2'h0, 1'b0), "write zero clears");
    chk(measurementReadyFlag, 1'b0, "flag cleared");
  endtask

  task automatic testStrobe();
    int n0;
    wr(ADDR_MODE, 32'h2);
    measEnable <= 2'h2;
    n0 = latchCnt;
    wr(ADDR_READBACK, 32'h1);
    cyc(6);
    chk(latchCnt - n0, 1, "one latch pulse");
    chk(measurementReadyFlag, 1'b1, "flag after copy");
    rd(ADDR_READBACK, bal(2'h0, 1'b1), "strobe reads zero");
  endtask

  task automatic testRefused();
    logic [2:0] md [4] = '{3'h0, 3'h1, 3'h2, 3'h2};
    logic [1:0] me [4] = '{2'h2, 2'h2, 2'h0, 2'h1};
    int n0;
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_MODE, {29'h0, md[i]});
      measEnable <= me[i];
      wr(ADDR_READBACK, 32'h0);
      n0 = latchCnt;
      wr(ADDR_READBACK, 32'h1);
      cyc(6);
      chk(latchCnt - n0, 0, "refused latch");
      chk(measurementReadyFlag, 1'b0, "refused flag");
    end
  endtask

  task automatic testLoose();
    acqPulse();
    wr(ADDR_READBACK, 32'hFFFF);
    rd(ADDR_READBACK, bal(2'h0, 1'b1), "loose bits zero");
    wr(ADDR_READBACK, 32'h0);
  endtask

  task automatic testIrq();
    wr(ADDR_IRQ_STATUS, 32'h7);
    wr(ADDR_IRQ_MASK, 32'h0);
    acqPulse();
    chk(irq, 1'b0, "masked irq quiet");
    rd(ADDR_IRQ_STATUS, 32'h1, "status sticky");
    wr(ADDR_IRQ_MASK, 32'h1);
    cyc(3);
    chk(irq, 1'b1, "irq unmasked");
    wr(ADDR_IRQ_STATUS, 32'h1);
    cyc(3);
    chk(irq, 1'b0, "irq cleared");
    rd(ADDR_IRQ_STATUS, 32'h0, "status cleared");
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    resetn = 1'b0;
    hsel = 1'b0;
    haddr = 12'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    balActive = 1'b0;
    balDoneNormal = 1'b0;
    balFault = 1'b0;
    acqResultsLoaded = 1'b0;
    measEnable = 2'h0;
    cyc(16);
    resetn <= 1'b1;
    cyc(3);
    rd(ADDR_READBACK, 32'h0, "reset value");
    testState();
    testReady();
    testStrobe();
    testRefused();
    testLoose();
    testIrq();
    wr(12'h010, 32'hFFFF_FFFF);
    rd(12'h010, 32'h0, "unmapped reads zero");
    wrap_up();
  end

  // whole run is about 150 cycles; this leaves ample margin
  initial
  begin
    #40000;
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end
endmodule // test_balancing_readback_control
